// ---- design/isp_regs.svh ----
// Purpose: Bit positions and encodings for the two-wire slave port
// Assumes: Included by the slave port design files
// Notes: Mode encodings sit in port_control_reg[3:0]
`ifndef ISP_REGS_SVH
`define ISP_REGS_SVH

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define ISP_CTRL_EN_BIT 5
`define ISP_CTRL_MODE_MSB 3
`define ISP_CTRL_MODE_LSB 0

// ----------------------------------------------------------------
// Mode encodings
// ----------------------------------------------------------------
`define ISP_MODE_SLV7 4'h6
`define ISP_MODE_SLV10 4'h7
`define ISP_MODE_FWM_IDLE 4'hB
`define ISP_MODE_SLV7_IRQ 4'hE
`define ISP_MODE_SLV10_IRQ 4'hF

// ----------------------------------------------------------------
// Address and byte layout
// ----------------------------------------------------------------
`define ISP_TEN_HDR 5'h1E
`define ISP_BITS_PER_BYTE 4'h8
`define ISP_LAST_TX_BIT 4'h7

`endif

// ---- design/isp_pkg.sv ----
// Purpose: Types shared by the two-wire slave port modules
// Assumes: Nothing
// Notes: State of each module is a single packed struct
package isp_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_ACK,
    ST_TX,
    ST_MACK
  } isp_state_t;

  typedef enum logic [1:0] {
    K_ADDR1,
    K_ADDR2,
    K_DATA
  } isp_kind_t;

  typedef struct packed {
    isp_state_t st;
    isp_kind_t kind;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic [7:0] txsh;
    logic rw;
    logic hi_match;
    logic nacked;
    logic mack;
    logic sda_oe;
    logic irq;
    logic ovf;
    logic push;
    logic [7:0] push_data;
    logic [2:0] scl_s;
    logic [2:0] sda_s;
  } isp_core_t;

  typedef struct packed {
    logic v0;
    logic v1;
    logic [7:0] d0;
    logic [7:0] d1;
  } isp_buf_t;

endpackage

// ---- design/isp_buf2.sv ----
// Purpose: Two-entry receive buffer between shift register and reader
// Assumes: Single clock, synchronous active-high reset
// Notes: Head entry drives the outputs directly from flops
`timescale 1ns/1ns
module isp_buf2 (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic in_valid,
  input wire logic [7:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [7:0] out_data,
  input wire logic out_ready
);

  isp_pkg::isp_buf_t q;
  isp_pkg::isp_buf_t n;
  logic pop;
  logic push;

  assign pop = q.v0 && out_ready;
  // Tail free means a push always has a slot, even without a pop
  assign push = in_valid && !q.v1;

  always_comb
  begin
    n = q;
    if (pop)
    begin
      if (q.v1)
      begin
        n.d0 = q.d1;
        n.v1 = 1'b0;
      end
      else
        n.v0 = 1'b0;
    end
    if (push)
    begin
      if (n.v0)
      begin
        n.d1 = in_data;
        n.v1 = 1'b1;
      end
      else
      begin
        n.d0 = in_data;
        n.v0 = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      q <= '0;
    else
      q <= n;
  end

  assign in_ready = !q.v1;
  assign out_valid = q.v0;
  assign out_data = q.d0;

endmodule // isp_buf2

// ---- design/isp_slave.sv ----
// Purpose: Two-wire serial port, slave mode, on the core clock
// Assumes: SCL comes from an external master; pull-ups are external
// Notes: Never stretches SCL; general call is not answered
`timescale 1ns/1ns
`include "isp_regs.svh"
module isp_slave (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [7:0] port_control_reg,
  input wire logic [9:0] slave_address_reg,
  input wire logic [1:0] portc_direction,
  input wire logic ovf_clear,
  input wire logic irq_clear,
  input wire logic rx_read,
  input wire logic [7:0] tx_data,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic scl_oe,
  output logic sda_out,
  output logic sda_oe,
  output logic [7:0] rx_tx_buffer,
  output logic buffer_full_flag,
  output logic receive_overflow_flag,
  output logic port_interrupt_flag
);

  isp_pkg::isp_core_t q;
  isp_pkg::isp_core_t n;
  logic [3:0] mode;
  logic en;
  logic mode10;
  logic slave_on;
  logic irq_mode;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic buf_ready;
  logic byte_end;
  logic hit;
  logic ack_ok;

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  assign mode = port_control_reg[`ISP_CTRL_MODE_MSB:`ISP_CTRL_MODE_LSB];
  assign en = port_control_reg[`ISP_CTRL_EN_BIT];
  assign mode10 = (mode == `ISP_MODE_SLV10) ||
                  (mode == `ISP_MODE_SLV10_IRQ);
  assign slave_on = mode10 || (mode == `ISP_MODE_SLV7) ||
                    (mode == `ISP_MODE_SLV7_IRQ);
  assign irq_mode = (mode == `ISP_MODE_SLV7_IRQ) ||
                    (mode == `ISP_MODE_SLV10_IRQ) ||
                    (mode == `ISP_MODE_FWM_IDLE);

  // ----------------------------------------------------------------
  // Bus events from synchronised pins (stage 1 and 2 onward)
  // ----------------------------------------------------------------
  assign scl_rise = q.scl_s[1] && !q.scl_s[2];
  assign scl_fall = !q.scl_s[1] && q.scl_s[2];
  // Data edges while SCL is steady high mark START and STOP
  assign start_c = q.scl_s[1] && q.scl_s[2] &&
                   !q.sda_s[1] && q.sda_s[2];
  assign stop_c = q.scl_s[1] && q.scl_s[2] &&
                  q.sda_s[1] && !q.sda_s[2];
  assign byte_end = (q.st == isp_pkg::ST_RX) && scl_fall &&
                    (q.bitcnt == `ISP_BITS_PER_BYTE);

  // ----------------------------------------------------------------
  // Address match and acknowledge decision
  // ----------------------------------------------------------------
  always_comb
  begin
    hit = 1'b0;
    case (q.kind)
      isp_pkg::K_ADDR1:
      begin
        if (!mode10)
          hit = (q.shreg[7:1] == slave_address_reg[6:0]);
        else if (q.shreg[7:3] == `ISP_TEN_HDR &&
                 q.shreg[2:1] == slave_address_reg[9:8])
          hit = !q.shreg[0] || q.hi_match;
      end
      isp_pkg::K_ADDR2:
        hit = (q.shreg == slave_address_reg[7:0]);
      default:
        hit = 1'b1;
    endcase
  end

  // Back-pressure from the buffer also withholds the ACK
  assign ack_ok = !buffer_full_flag && !q.ovf && buf_ready;

  // ----------------------------------------------------------------
  // Main sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    n = q;
    n.push = 1'b0;
    n.scl_s = {q.scl_s[1:0], scl_in};
    n.sda_s = {q.sda_s[1:0], sda_in};
    // Clears come first so that a same-cycle set wins
    n.ovf = q.ovf && !ovf_clear;
    n.irq = q.irq && !irq_clear;
    if (!en)
    begin
      n.st = isp_pkg::ST_IDLE;
      n.sda_oe = 1'b0;
      n.hi_match = 1'b0;
    end
    else if (start_c)
    begin
      n.st = slave_on ? isp_pkg::ST_RX : isp_pkg::ST_IDLE;
      n.kind = isp_pkg::K_ADDR1;
      n.bitcnt = 4'h0;
      n.sda_oe = 1'b0;
      if (irq_mode)
        n.irq = 1'b1;
    end
    else if (stop_c)
    begin
      n.st = isp_pkg::ST_IDLE;
      n.sda_oe = 1'b0;
      n.hi_match = 1'b0;
      if (irq_mode)
        n.irq = 1'b1;
    end
    else
    begin
      case (q.st)
        isp_pkg::ST_RX:
        begin
          if (scl_rise)
          begin
            n.shreg = {q.shreg[6:0], q.sda_s[2]};
            n.bitcnt = q.bitcnt + 4'h1;
          end
          else if (byte_end)
          begin
            if (!hit)
              n.st = isp_pkg::ST_IDLE;
            else
            begin
              n.st = isp_pkg::ST_ACK;
              n.irq = 1'b1;
              n.nacked = !ack_ok;
              n.sda_oe = ack_ok;
              n.push = ack_ok;
              n.push_data = q.shreg;
              if (buffer_full_flag)
                n.ovf = 1'b1;
              if (q.kind == isp_pkg::K_ADDR1)
              begin
                n.rw = q.shreg[0];
                n.kind = (mode10 && !q.shreg[0]) ?
                         isp_pkg::K_ADDR2 : isp_pkg::K_DATA;
              end
              else
                n.kind = isp_pkg::K_DATA;
              if (q.kind == isp_pkg::K_ADDR2)
                n.hi_match = 1'b1;
            end
          end
        end
        isp_pkg::ST_ACK:
        begin
          if (scl_fall)
          begin
            n.bitcnt = 4'h0;
            n.sda_oe = 1'b0;
            if (q.nacked)
              n.st = isp_pkg::ST_IDLE;
            else if (q.rw)
            begin
              n.st = isp_pkg::ST_TX;
              n.txsh = tx_data;
              n.sda_oe = !tx_data[7];
            end
            else
              n.st = isp_pkg::ST_RX;
          end
        end
        isp_pkg::ST_TX:
        begin
          if (scl_fall)
          begin
            if (q.bitcnt == `ISP_LAST_TX_BIT)
            begin
              n.st = isp_pkg::ST_MACK;
              n.sda_oe = 1'b0;
            end
            else
            begin
              n.bitcnt = q.bitcnt + 4'h1;
              n.txsh = {q.txsh[6:0], 1'b0};
              n.sda_oe = !q.txsh[6];
            end
          end
        end
        isp_pkg::ST_MACK:
        begin
          if (scl_rise)
            n.mack = !q.sda_s[2];
          else if (scl_fall)
          begin
            n.irq = 1'b1;
            n.bitcnt = 4'h0;
            // Master NACK ends the read; slave then idles until the next START
            n.st = q.mack ? isp_pkg::ST_TX : isp_pkg::ST_IDLE;
            n.txsh = tx_data;
            n.sda_oe = q.mack && !tx_data[7];
          end
        end
        default:
          n.st = isp_pkg::ST_IDLE;
      endcase
    end
    if (portc_direction != 2'h3)
      n.sda_oe = 1'b0;
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      q <= '0;
    else
      q <= n;
  end

  // ----------------------------------------------------------------
  // Receive buffer
  // ----------------------------------------------------------------
  isp_buf2 u_buf (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .in_valid(q.push),
    .in_data(q.push_data),
    .in_ready(buf_ready),
    .out_valid(buffer_full_flag),
    .out_data(rx_tx_buffer),
    .out_ready(rx_read)
  );

  // ----------------------------------------------------------------
  // Pins: open drain, only ever pulled low
  // ----------------------------------------------------------------
  assign sda_out = 1'b0;
  assign sda_oe = q.sda_oe;
  assign scl_out = 1'b0;
  assign scl_oe = 1'b0;
  assign receive_overflow_flag = q.ovf;
  assign port_interrupt_flag = q.irq;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  sequence s_byte_hit;
    byte_end && hit && !start_c && !stop_c && en;
  endsequence

  sequence s_ack_held;
    sda_oe [*2];
  endsequence

  property p_disabled_idle;
    !en |=> (q.st == isp_pkg::ST_IDLE) && !sda_oe;
  endproperty
  a_disabled_idle: assert property (p_disabled_idle)
    else $error("port active while disabled");

  property p_dir_gate;
    (portc_direction != 2'h3) |=> !sda_oe;
  endproperty
  a_dir_gate: assert property (p_dir_gate)
    else $error("SDA driven with pin not input");

  property p_ack_load;
    (s_byte_hit and (ack_ok && (portc_direction == 2'h3)))
      |=> (q.push and s_ack_held) ##1 buffer_full_flag;
  endproperty
  a_ack_load: assert property (p_ack_load)
    else $error("ACK or buffer load missing");

  property p_nack;
    s_byte_hit and !ack_ok |=> !sda_oe && !q.push;
  endproperty
  a_nack: assert property (p_nack)
    else $error("ACK given with full or overflow");

  property p_nack_irq;
    s_byte_hit and !ack_ok |=> port_interrupt_flag;
  endproperty
  a_nack_irq: assert property (p_nack_irq)
    else $error("interrupt flag not set on NACK");

  property p_ovf_hold;
    receive_overflow_flag && !ovf_clear |=> receive_overflow_flag;
  endproperty
  a_ovf_hold: assert property (p_ovf_hold)
    else $error("overflow cleared without software");

  property p_start_irq;
    en && irq_mode && start_c |=> port_interrupt_flag;
  endproperty
  a_start_irq: assert property (p_start_irq)
    else $error("START interrupt missing");

  property p_miss_idle;
    byte_end && !hit && en && !start_c && !stop_c
      |=> (q.st == isp_pkg::ST_IDLE) && !sda_oe;
  endproperty
  a_miss_idle: assert property (p_miss_idle)
    else $error("unmatched address answered");

  property p_tx_bit;
    (q.st == isp_pkg::ST_TX) && (portc_direction == 2'h3) && en
      && !scl_fall && !start_c && !stop_c
      |=> sda_oe == $past(sda_oe);
  endproperty
  a_tx_bit: assert property (p_tx_bit)
    else $error("TX data changed away from SCL fall");

endmodule // isp_slave

// ---- dv/isp_master.sv ----
// Purpose: Behavioural two-wire bus master facing the slave port
// Assumes: The bench resolves open-drain lines with pull-ups
// Notes: Bit period 125 ns; SCL stands high between frames
`timescale 1ns/1ns
module isp_master (
  output logic scl_low,
  output logic sda_low,
  input wire logic sda
);
  initial
  begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end

  // ----------------------------------------------------------------
  // Bit and frame primitives
  // ----------------------------------------------------------------
  // Data moves mid-low, sampled mid-high, so slave drive has time
  task automatic bit_io(input logic b, output logic r);
    #30 sda_low = !b;
    #32 scl_low = 1'b0;
    #31 r = sda;
    #32 scl_low = 1'b1;
  endtask

  task automatic start;
    #63 sda_low = 1'b1;
    #63 scl_low = 1'b1;
  endtask

  task automatic stop;
    sda_low = 1'b1;
    #62 scl_low = 1'b0;
    #63 sda_low = 1'b0;
  endtask

  // MSB first, ninth clock returns the acknowledge
  task automatic wr(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask

  task automatic rd(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(!ack, r);
  endtask
endmodule // isp_master

// ---- dv/i2c_slave_serial_port_test.sv ----
// Purpose: Self-checking bench for the two-wire slave port
// Assumes: isp_master plays the bus master
// Notes: Own address 10'h2A5, 7-bit write byte 8'h4A
`timescale 1ns/1ns
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fails++; \
  $display("mismatch at %0t: %h vs %h", $time, a, b); end end
module i2c_slave_serial_port_test;
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] b;
    logic ack;
    logic irq;
  } isp_row_t;
  logic core_clk, sys_rst, ovf_clear, irq_clear, rx_read, a;
  logic [7:0] ctrl, tx_data, d;
  logic [9:0] saddr;
  logic [1:0] dir;
  wire scl_oe, scl_out, sda_oe, sda_out, bf, ovf, irq, scl_low, sda_low;
  wire [7:0] buf_q;
  wire scl = !(scl_low || (scl_oe && !scl_out));
  wire sda = !(sda_low || (sda_oe && !sda_out));
  int fails = 0;
  int check_count = 0;
  int cyc = 0;
  isp_row_t rows [9] = '{
    '{8'h26, 8'h4A, 1'b1, 1'b1},
    '{8'h26, 8'h4C, 1'b0, 1'b0},
    '{8'h26, 8'h00, 1'b0, 1'b0},
    '{8'h06, 8'h4A, 1'b0, 1'b0},
    '{8'h2E, 8'h4A, 1'b1, 1'b1},
    '{8'h2E, 8'h4C, 1'b0, 1'b1},
    '{8'h2B, 8'h4A, 1'b0, 1'b1},
    '{8'h2F, 8'h4A, 1'b0, 1'b1},
    '{8'h2A, 8'h4A, 1'b0, 1'b0}
  };

  isp_slave dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .port_control_reg(ctrl),
    .slave_address_reg(saddr), .portc_direction(dir),
    .ovf_clear(ovf_clear), .irq_clear(irq_clear), .rx_read(rx_read),
    .tx_data(tx_data), .scl_in(scl), .sda_in(sda), .scl_out(scl_out),
    .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe),
    .rx_tx_buffer(buf_q), .buffer_full_flag(bf),
    .receive_overflow_flag(ovf), .port_interrupt_flag(irq)
  );
  isp_master m (
    .scl_low(scl_low),
    .sda_low(sda_low),
    .sda(sda)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Hang guard, well above the few thousand cycles needed
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      fails++;
      close_out;
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // k = {ovf_clear, irq_clear, rx_read}
  task automatic pulse(input logic [2:0] k);
    @(posedge core_clk);
    #1 {ovf_clear, irq_clear, rx_read} = k;
    @(posedge core_clk);
    #1 {ovf_clear, irq_clear, rx_read} = 3'b000;
    settle;
  endtask

  task automatic settle;
    repeat (8) @(posedge core_clk);
    #1;
  endtask

  task automatic close_out;
    $display("checks %0d, fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial
  begin
    sys_rst = 1'b1;
    {ovf_clear, irq_clear, rx_read} = 3'b000;
    ctrl = 8'h00;
    tx_data = 8'h00;
    saddr = 10'h2A5;
    dir = 2'b11;
    repeat (16) @(posedge core_clk);
    #1 sys_rst = 1'b0;
    settle;
    `CHK({bf, ovf, irq, sda_oe}, 4'h0)
    foreach (rows[i])
    begin
      ctrl = rows[i].ctrl;
      pulse(3'b010);
      m.start;
      m.wr(rows[i].b, a);
      m.stop;
      settle;
      `CHK(a, rows[i].ack)
      `CHK(irq, rows[i].irq)
      `CHK(bf, rows[i].ack)
      if (rows[i].ack)
      begin
        `CHK(buf_q, rows[i].b)
        pulse(3'b001);
      end
    end
    ctrl = 8'h26;
    pulse(3'b010);
    m.start;
    m.wr(8'h4A, a);
    pulse(3'b001);
    m.wr(8'h3C, a);
    `CHK(a, 1'b1)
    m.wr(8'h5C, a);
    `CHK(a, 1'b0)
    m.stop;
    settle;
    `CHK({buf_q, ovf, irq}, {8'h3C, 2'b11})
    pulse(3'b001);
    `CHK({bf, ovf}, 2'b01)
    m.start;
    m.wr(8'h4A, a);
    m.stop;
    settle;
    `CHK({a, bf}, 2'b00)
    pulse(3'b100);
    `CHK(ovf, 1'b0)
    tx_data = 8'hA6;
    m.start;
    m.wr(8'h4B, a);
    m.rd(1'b0, d);
    m.stop;
    settle;
    `CHK({a, d}, {1'b1, 8'hA6})
    pulse(3'b001);
    ctrl = 8'h27;
    m.start;
    m.wr(8'hF4, a);
    `CHK(a, 1'b1)
    pulse(3'b001);
    m.wr(8'hA5, a);
    m.stop;
    settle;
    `CHK({a, buf_q}, {1'b1, 8'hA5})
    `CHK({scl_oe, sda_oe}, 2'b00)
    `CHK({scl_out, sda_out}, 2'b00)
    pulse(3'b001);
    close_out;
  end
endmodule // i2c_slave_serial_port_test
